// >>> hdl/fkd_map.vh
`ifndef FKD_MAP_VH
`define FKD_MAP_VH

// ----------------------------------------------------------------
// mode keys, counted as mid-level pulses in the mode field
// ----------------------------------------------------------------
`define FKD_MODE_BLOW     10'h001
`define FKD_MODE_TRY      10'h002

// ----------------------------------------------------------------
// parameter register keys
// ----------------------------------------------------------------
`define FKD_PKEY_GAIN     10'h001
`define FKD_PKEY_DUTY     10'h002
`define FKD_PKEY_FREQ     10'h003
`define FKD_PKEY_LOCK     10'h006

// ----------------------------------------------------------------
// field codes and bit positions
// ----------------------------------------------------------------
`define FKD_GAIN_MAX      10'h1ff
`define FKD_GAIN_R2_BIT   8
`define FKD_DUTY_MAX      10'h1ff
`define FKD_DUTY_DEC_BIT  8
`define FKD_FREQ_MAX      10'h010
`define FKD_FREQ_MIN_CODE 10'h00f
`define FKD_CAL_BIT       4
`define FKD_LOCK_CODE     10'h200

// ----------------------------------------------------------------
// register offsets and reset values
// ----------------------------------------------------------------
`define FKD_REG_STATUS    8'h00
`define FKD_REG_GAIN      8'h04
`define FKD_REG_DUTY      8'h08
`define FKD_REG_FREQ      8'h0c
`define FKD_REG_CTRL      8'h10
`define FKD_REG_FUSE      8'h14
`define FKD_CTRL_RST      1'b1

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FKD_CLK_HZ        250000000
`define FKD_CARRIER_HZ    1000
`define FKD_CAL_MS        50
`define FKD_CAL_PERIODS   ((`FKD_CAL_MS * `FKD_CARRIER_HZ) / 1000)
`define FKD_BASE_CYC      (`FKD_CLK_HZ / `FKD_CARRIER_HZ)

`endif

// >>> hdl/fkd_sync.v
`timescale 1ns/1ns
module fkd_sync #(
   parameter WIDTH = 2
) (
   input  wire             aclk,     // system clock
   input  wire             aresetn,  // sync reset, low active
   input  wire [WIDTH-1:0] async_in, // pin level
   output wire [WIDTH-1:0] sync_out  // level after two flops
);

   reg [WIDTH-1:0] meta_ff;
   reg [WIDTH-1:0] sync_ff;

   always @(posedge aclk) begin
      if (!aresetn) begin
         meta_ff <= {WIDTH{1'b0}};
         sync_ff <= {WIDTH{1'b0}};
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;

endmodule

// >>> hdl/fkd_top.v
`timescale 1ns/1ns
`include "fkd_map.vh"
module fkd_top #(
   parameter PER_W     = 24,
   parameter BASE_CYC  = `FKD_BASE_CYC,
   parameter STEP_CYC  = `FKD_BASE_CYC / 32,
   parameter CAL_COUNT = `FKD_CAL_PERIODS
) (
   input  wire             aclk,             // 250 MHz clock
   input  wire             aresetn,          // supply cycle, sync, low active
   input  wire             fuse_erase_n,     // blank fuse array, low active
   input  wire             mid_level_pulse,  // mid-level comparator, async
   input  wire             high_level_pulse, // high-level comparator, async
   input  wire [PER_W-1:0] field_high_cyc,   // measured field high time
   output reg              pwm_out_ff,       // carrier output
   output reg              cal_active_ff,    // calibration interval running
   output reg              locked_ff,        // lock fuse blown
   output reg  [8:0]       gain_code_ff,     // effective gain code
   output reg              gain_range2_ff,   // gain in second range
   output reg  [8:0]       duty_code_ff,     // effective duty code
   output reg              duty_down_ff,     // duty in decreasing half
   output reg  [3:0]       freq_code_ff,     // effective frequency code
   input  wire [7:0]       s_axi_awaddr,     // write address
   input  wire [2:0]       s_axi_awprot,     // unused protection
   input  wire             s_axi_awvalid,    // write address valid
   output reg              s_axi_awready,    // write address ready
   input  wire [31:0]      s_axi_wdata,      // write data
   input  wire [3:0]       s_axi_wstrb,      // write strobes
   input  wire             s_axi_wvalid,     // write data valid
   output reg              s_axi_wready,     // write data ready
   output reg  [1:0]       s_axi_bresp,      // write response
   output reg              s_axi_bvalid,     // write response valid
   input  wire             s_axi_bready,     // write response ready
   input  wire [7:0]       s_axi_araddr,     // read address
   input  wire [2:0]       s_axi_arprot,     // unused protection
   input  wire             s_axi_arvalid,    // read address valid
   output reg              s_axi_arready,    // read address ready
   output reg  [31:0]      s_axi_rdata,      // read data
   output reg  [1:0]       s_axi_rresp,      // read response
   output reg              s_axi_rvalid,     // read data valid
   input  wire             s_axi_rready      // read data ready
);

   localparam ST_MODE = 3'd0;
   localparam ST_REG  = 3'd1;
   localparam ST_FLD  = 3'd2;
   localparam ST_HOLD = 3'd3;

   localparam [PER_W-1:0] BASE_L = BASE_CYC[PER_W-1:0];
   localparam [PER_W-1:0] STEP_L = STEP_CYC[PER_W-1:0];
   localparam [7:0]       CAL_L  = CAL_COUNT[7:0];

   // ----------------------------------------------------------------
   // pin synchronisation and edge detect
   // ----------------------------------------------------------------
   wire [1:0] pin_s;
   reg  [1:0] pin_d_ff;
   wire       mid_fall;
   wire       high_rise;

   fkd_sync #(
      .WIDTH   (2)
   ) u_sync (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in ({high_level_pulse, mid_level_pulse}),
      .sync_out (pin_s)
   );

   always @(posedge aclk) begin
      if (!aresetn) begin
         pin_d_ff <= 2'h0;
      end else begin
         pin_d_ff <= pin_s;
      end
   end

   assign mid_fall  = pin_d_ff[0] & ~pin_s[0];
   assign high_rise = ~pin_d_ff[1] & pin_s[1];

   // ----------------------------------------------------------------
   // programming state machine
   // ----------------------------------------------------------------
   reg  [2:0]  state_ff;
   reg  [2:0]  nxt_state;
   reg  [9:0]  cnt_ff;
   reg  [9:0]  nxt_cnt;
   reg         try_ff;
   reg         nxt_try;
   reg  [9:0]  key_ff;
   reg  [9:0]  nxt_key;
   reg  [8:0]  try_gain_ff;
   reg  [8:0]  try_duty_ff;
   reg  [4:0]  try_freq_ff;
   reg  [8:0]  fuse_gain_ff;
   reg  [8:0]  fuse_duty_ff;
   reg  [4:0]  fuse_freq_ff;
   reg         fuse_lock_ff;
   reg         prog_en_ff;
   reg         blow;
   reg  [9:0]  max_code;

   wire        prog_ok = prog_en_ff & ~fuse_lock_ff;

   always @* begin
      case (key_ff)
         `FKD_PKEY_GAIN: max_code = `FKD_GAIN_MAX;
         `FKD_PKEY_DUTY: max_code = `FKD_DUTY_MAX;
         `FKD_PKEY_FREQ: max_code = `FKD_FREQ_MAX;
         `FKD_PKEY_LOCK: max_code = `FKD_LOCK_CODE;
         default:        max_code = 10'h000;
      endcase
   end

   always @* begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      nxt_try   = try_ff;
      nxt_key   = key_ff;
      blow      = 1'b0;
      case (state_ff)
         ST_MODE: begin
            if (mid_fall && cnt_ff != `FKD_MODE_TRY) begin
               nxt_cnt = cnt_ff + 10'h001;
            end
            if (high_rise) begin
               nxt_cnt = 10'h000;
               if (cnt_ff == `FKD_MODE_BLOW) begin
                  nxt_try   = 1'b0;
                  nxt_state = ST_REG;
               end else if (cnt_ff == `FKD_MODE_TRY) begin
                  nxt_try   = 1'b1;
                  nxt_state = ST_REG;
               end
            end
         end
         ST_REG: begin
            if (mid_fall && cnt_ff != `FKD_PKEY_LOCK) begin
               nxt_cnt = cnt_ff + 10'h001;
            end
            if (high_rise) begin
               nxt_key   = cnt_ff;
               nxt_cnt   = 10'h000;
               nxt_state = ST_FLD;
            end
         end
         ST_FLD: begin
            if (mid_fall && cnt_ff < max_code) begin
               nxt_cnt = cnt_ff + 10'h001;
            end
            if (high_rise) begin
               nxt_cnt = 10'h000;
               if (try_ff) begin
                  nxt_state = ST_MODE;
               end else begin
                  blow      = 1'b1;
                  nxt_state = ST_HOLD;
               end
            end
         end
         ST_HOLD: begin
            nxt_state = ST_HOLD;
         end
         default: begin
            nxt_state = ST_MODE;
         end
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= ST_MODE;
         cnt_ff   <= 10'h000;
         try_ff   <= 1'b0;
         key_ff   <= 10'h000;
      end else if (prog_ok) begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         try_ff   <= nxt_try;
         key_ff   <= nxt_key;
      end
   end

   // ----------------------------------------------------------------
   // volatile field codes, cleared by a supply cycle
   // ----------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         try_gain_ff <= 9'h000;
         try_duty_ff <= 9'h000;
         try_freq_ff <= 5'h00;
      end else if (prog_ok && state_ff == ST_FLD && !high_rise) begin
         case (key_ff)
            `FKD_PKEY_GAIN: try_gain_ff <= nxt_cnt[8:0];
            `FKD_PKEY_DUTY: try_duty_ff <= nxt_cnt[8:0];
            `FKD_PKEY_FREQ: try_freq_ff <= nxt_cnt[4:0];
            default: begin
               try_gain_ff <= try_gain_ff;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // fuse array, survives supply cycles
   // ----------------------------------------------------------------
   always @(posedge aclk) begin
      if (!fuse_erase_n) begin
         fuse_gain_ff <= 9'h000;
         fuse_duty_ff <= 9'h000;
         fuse_freq_ff <= 5'h00;
         fuse_lock_ff <= 1'b0;
      end else if (prog_ok && blow) begin
         case (key_ff)
            `FKD_PKEY_GAIN: fuse_gain_ff <= fuse_gain_ff | cnt_ff[8:0];
            `FKD_PKEY_DUTY: fuse_duty_ff <= fuse_duty_ff | cnt_ff[8:0];
            `FKD_PKEY_FREQ: fuse_freq_ff <= fuse_freq_ff | cnt_ff[4:0];
            `FKD_PKEY_LOCK: fuse_lock_ff <= (cnt_ff == `FKD_LOCK_CODE);
            default: begin
               fuse_lock_ff <= fuse_lock_ff;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // effective parameter values
   // ----------------------------------------------------------------
   wire [8:0] eff_gain = try_gain_ff | fuse_gain_ff;
   wire [8:0] eff_duty = try_duty_ff | fuse_duty_ff;
   wire [4:0] eff_freq = try_freq_ff | fuse_freq_ff;

   always @(posedge aclk) begin
      if (!aresetn) begin
         gain_code_ff   <= 9'h000;
         gain_range2_ff <= 1'b0;
         duty_code_ff   <= 9'h000;
         duty_down_ff   <= 1'b0;
         freq_code_ff   <= 4'h0;
         locked_ff      <= 1'b0;
      end else begin
         gain_code_ff   <= eff_gain;
         gain_range2_ff <= eff_gain[`FKD_GAIN_R2_BIT];
         duty_code_ff   <= eff_duty;
         duty_down_ff   <= eff_duty[`FKD_DUTY_DEC_BIT];
         freq_code_ff   <= eff_freq[3:0];
         locked_ff      <= fuse_lock_ff;
      end
   end

   // ----------------------------------------------------------------
   // carrier and calibration interval
   // ----------------------------------------------------------------
   reg  [PER_W-1:0] phase_ff;
   reg  [PER_W-1:0] period;
   reg  [PER_W-1:0] thresh;
   reg  [7:0]       cal_cnt_ff;
   reg              started_ff;
   wire             wrap;

   always @* begin
      period = BASE_L + STEP_L * {{(PER_W-4){1'b0}}, eff_freq[3:0]};
      if (cal_active_ff) begin
         thresh = {1'b0, period[PER_W-1:1]};
      end else begin
         thresh = field_high_cyc;
      end
   end

   assign wrap = (phase_ff >= period - {{(PER_W-1){1'b0}}, 1'b1});

   always @(posedge aclk) begin
      if (!aresetn) begin
         phase_ff   <= {PER_W{1'b0}};
         pwm_out_ff <= 1'b0;
      end else begin
         if (wrap) begin
            phase_ff <= {PER_W{1'b0}};
         end else begin
            phase_ff <= phase_ff + {{(PER_W-1){1'b0}}, 1'b1};
         end
         pwm_out_ff <= (phase_ff < thresh);
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         started_ff    <= 1'b0;
         cal_active_ff <= 1'b0;
         cal_cnt_ff    <= 8'h00;
      end else begin
         started_ff <= 1'b1;
         if (!started_ff) begin
            cal_active_ff <= fuse_freq_ff[`FKD_CAL_BIT];
         end else if (cal_active_ff && wrap) begin
            if (cal_cnt_ff == CAL_L - 8'h01) begin
               cal_active_ff <= 1'b0;
            end
            cal_cnt_ff <= cal_cnt_ff + 8'h01;
         end
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite write channel
   // ----------------------------------------------------------------
   reg         aw_got_ff;
   reg         w_got_ff;
   reg  [7:0]  awaddr_ff;
   reg  [31:0] wdata_ff;
   reg  [3:0]  wstrb_ff;
   wire        wr_go = aw_got_ff & w_got_ff & ~s_axi_bvalid;

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_ff     <= 1'b0;
         w_got_ff      <= 1'b0;
         awaddr_ff     <= 8'h00;
         wdata_ff      <= 32'h0000_0000;
         wstrb_ff      <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
         prog_en_ff    <= `FKD_CTRL_RST;
      end else begin
         s_axi_awready <= ~aw_got_ff & ~(s_axi_awvalid & s_axi_awready);
         s_axi_wready  <= ~w_got_ff & ~(s_axi_wvalid & s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_got_ff    <= 1'b0;
            w_got_ff     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case ({awaddr_ff[7:2], 2'b00})
               `FKD_REG_CTRL: begin
                  s_axi_bresp <= 2'h0;
                  if (wstrb_ff[0]) begin
                     prog_en_ff <= wdata_ff[0];
                  end
               end
               `FKD_REG_STATUS, `FKD_REG_GAIN, `FKD_REG_DUTY,
               `FKD_REG_FREQ, `FKD_REG_FUSE: begin
                  s_axi_bresp <= 2'h2;
               end
               default: begin
                  s_axi_bresp <= 2'h3;
               end
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite read channel
   // ----------------------------------------------------------------
   reg [31:0] rd_word;
   reg [1:0]  rd_resp;

   always @* begin
      rd_resp = 2'h0;
      case ({s_axi_araddr[7:2], 2'b00})
         `FKD_REG_STATUS: rd_word = {22'h0, try_ff, state_ff, prog_ok,
                                     fuse_lock_ff, cal_active_ff, pwm_out_ff, 2'h0};
         `FKD_REG_GAIN:   rd_word = {23'h0, eff_gain};
         `FKD_REG_DUTY:   rd_word = {23'h0, eff_duty};
         `FKD_REG_FREQ:   rd_word = {27'h0, eff_freq};
         `FKD_REG_CTRL:   rd_word = {31'h0, prog_en_ff};
         `FKD_REG_FUSE:   rd_word = {8'h0, fuse_lock_ff, fuse_freq_ff,
                                     fuse_duty_ff, fuse_gain_ff};
         default: begin
            rd_word = 32'h0000_0000;
            rd_resp = 2'h3;
         end
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'h0;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_resp;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule

// >>> tb/fkd_prog.sv
`timescale 1ns/1ns
module fkd_prog (
   input  wire aclk,             // system clock
   output reg  mid_level_pulse,  // mid-level supply pulse
   output reg  high_level_pulse  // high-level supply pulse
);
   // ------------------------------------------------------------
   // pulse trains, each level held 5 clocks for edge detection
   // ------------------------------------------------------------
   initial begin
      mid_level_pulse = 1'b0;
      high_level_pulse = 1'b0;
   end
   task mids(input int n);
      repeat (n) begin
         @(posedge aclk);
         mid_level_pulse <= 1'b1;
         repeat (5) @(posedge aclk);
         mid_level_pulse <= 1'b0;
         repeat (5) @(posedge aclk);
      end
   endtask
   task high();
      @(posedge aclk);
      high_level_pulse <= 1'b1;
      repeat (5) @(posedge aclk);
      high_level_pulse <= 1'b0;
      repeat (5) @(posedge aclk);
   endtask
   // mode key, register key, code, each followed by its closing high pulse
   task seq(input int m, input int k, input int c);
      mids(m);
      high();
      mids(k);
      high();
      mids(c);
      high();
   endtask
endmodule

// >>> tb/fkd_top_sva.sv
`timescale 1ns/1ns
module fkd_chk #(
   parameter BASE_CYC  = 40,
   parameter STEP_CYC  = 4,
   parameter CAL_COUNT = 5
) (
   input wire       aclk,           // clock
   input wire       aresetn,        // reset, low active
   input wire       pwm_out_ff,     // carrier output
   input wire       cal_active_ff,  // calibration running
   input wire       locked_ff,      // lock state
   input wire [8:0] gain_code_ff,   // gain code
   input wire       gain_range2_ff, // gain range two
   input wire [8:0] duty_code_ff,   // duty code
   input wire       duty_down_ff,   // duty decreasing
   input wire [3:0] freq_code_ff,   // frequency code
   input wire       s_axi_arvalid,  // read addr valid
   input wire       s_axi_arready,  // read addr ready
   input wire       s_axi_rvalid,   // read data valid
   input wire       s_axi_bvalid,   // write resp valid
   input wire       s_axi_bready,   // write resp ready
   input wire [1:0] s_axi_bresp     // write resp
);
   reg  [31:0] cal_cyc_ff;
   reg  [31:0] hi_run_ff;
   reg  [2:0]  run_cnt_ff;
   wire [31:0] per = BASE_CYC + freq_code_ff * STEP_CYC;
   // ------------------------------------------------------------
   // helper counters
   // ------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         cal_cyc_ff <= 32'h0;
         hi_run_ff <= 32'h0;
         run_cnt_ff <= 3'h0;
      end else begin
         cal_cyc_ff <= cal_active_ff ? cal_cyc_ff + 32'h1 : cal_cyc_ff;
         hi_run_ff <= pwm_out_ff ? hi_run_ff + 32'h1 : 32'h0;
         run_cnt_ff <= (run_cnt_ff == 3'h7) ? run_cnt_ff : run_cnt_ff + 3'h1;
      end
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   property p_cal_len;
      $fell(cal_active_ff) |-> cal_cyc_ff + 2 >= CAL_COUNT * per
         && cal_cyc_ff <= CAL_COUNT * per + 2;
   endproperty
   property p_cal_half;
      $past(cal_active_ff) && $fell(pwm_out_ff) |-> hi_run_ff + 1 >= per / 2
         && hi_run_ff <= per / 2 + 1;
   endproperty
   property p_gain_rng;
      gain_range2_ff == gain_code_ff[8];
   endproperty
   property p_duty_dir;
      duty_down_ff == duty_code_ff[8];
   endproperty
   property p_lock_hold;
      locked_ff |=> locked_ff;
   endproperty
   property p_lock_frz;
      locked_ff && run_cnt_ff == 3'h7 |=> $stable(gain_code_ff)
         && $stable(duty_code_ff) && $stable(freq_code_ff);
   endproperty
   property p_b_stand;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   property p_r_lat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_cal_len: assert property (p_cal_len) else $error("calibration length off");
   a_cal_half: assert property (p_cal_half) else $error("calibration duty off");
   a_gain_rng: assert property (p_gain_rng) else $error("gain range wrong");
   a_duty_dir: assert property (p_duty_dir) else $error("duty direction wrong");
   a_lock_hold: assert property (p_lock_hold) else $error("lock dropped");
   a_lock_frz: assert property (p_lock_frz) else $error("code moved when locked");
   a_b_stand: assert property (p_b_stand) else $error("write resp not retired");
   a_r_lat: assert property (p_r_lat) else $error("read resp late");
   c_cal: cover property ($fell(cal_active_ff));
   c_lock: cover property ($rose(locked_ff));
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind fkd_top fkd_chk #(.BASE_CYC(BASE_CYC), .STEP_CYC(STEP_CYC), .CAL_COUNT(CAL_COUNT)) chk_u (
   .aclk(aclk), .aresetn(aresetn), .pwm_out_ff(pwm_out_ff),
   .cal_active_ff(cal_active_ff), .locked_ff(locked_ff), .gain_code_ff(gain_code_ff),
   .gain_range2_ff(gain_range2_ff), .duty_code_ff(duty_code_ff),
   .duty_down_ff(duty_down_ff), .freq_code_ff(freq_code_ff),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp));

// >>> tb/fkd_top_tb.sv
`timescale 1ns/1ns
`include "fkd_map.vh"
module fkd_top_tb;
   logic aclk, aresetn, erase_n, mid, high;
   logic [23:0] fhc;
   logic pwm, cal, lck, g2, ddn;
   logic [8:0] gain, duty;
   logic [3:0] freq;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [1:0] bresp, rresp;
   logic [3:0] wstrb;
   int miscompares, cmp_count, n;
   fkd_top #(.BASE_CYC(40), .STEP_CYC(4), .CAL_COUNT(5)) dut_u (
      .aclk(aclk), .aresetn(aresetn), .fuse_erase_n(erase_n),
      .mid_level_pulse(mid), .high_level_pulse(high), .field_high_cyc(fhc),
      .pwm_out_ff(pwm), .cal_active_ff(cal), .locked_ff(lck), .gain_code_ff(gain),
      .gain_range2_ff(g2), .duty_code_ff(duty), .duty_down_ff(ddn), .freq_code_ff(freq),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   fkd_prog p_u (.aclk(aclk), .mid_level_pulse(mid), .high_level_pulse(high));
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   // ------------------------------------------------------------
   // checking and bus tasks
   // ------------------------------------------------------------
   task chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task finish_test();
      $display("compares=%0d miscompares=%0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
      bit ad, wd;
      ad = 0;
      wd = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (!ad && awready) begin
            ad = 1;
            awvalid <= 1'b0;
         end
         if (!wd && wready) begin
            wd = 1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge aclk);
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, r});
   endtask
   task rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge aclk);
      rready <= 1'b0;
      v = rdata;
      chk({30'h0, rresp}, {30'h0, r});
   endtask
   task cycle_supply();
      aresetn <= 1'b0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      erase_n <= 1'b1;
      repeat (3) @(posedge aclk);
   endtask
   // ------------------------------------------------------------
   // watchdog
   // ------------------------------------------------------------
   initial begin
      #400000;
      miscompares++;
      finish_test();
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
      {miscompares, cmp_count} = '0;
      wstrb = 4'hf;
      aresetn = 1'b0;
      erase_n = 1'b0;
      fhc = 24'h00000a;
      cycle_supply();
      rd(`FKD_REG_STATUS, d, 2'h0);
      chk(d & 32'h18, 32'h0);
      rd(`FKD_REG_CTRL, d, 2'h0);
      chk(d & 32'h1, 32'h1);
      wr(`FKD_REG_CTRL, 32'h1, 2'h0);
      wstrb <= 4'he;
      wr(`FKD_REG_CTRL, 32'h0, 2'h0);
      wstrb <= 4'hf;
      rd(`FKD_REG_CTRL, d, 2'h0);
      chk(d & 32'h1, 32'h1);
      wr(`FKD_REG_GAIN, 32'h5, 2'h2);
      rd(8'h40, d, 2'h3);
      chk(d, 32'h0);
      p_u.seq(2, 1, 3);
      chk({23'h0, gain}, 32'h3);
      p_u.seq(2, 2, 256);
      chk({22'h0, ddn, duty}, 32'h300);
      p_u.seq(2, 1, 600);
      chk({22'h0, g2, gain}, 32'h3ff);
      p_u.seq(2, 3, 20);
      rd(`FKD_REG_FREQ, d, 2'h0);
      chk(d & 32'h1f, 32'h10);
      cycle_supply();
      chk({13'h0, cal, gain, duty}, 32'h0);
      p_u.seq(1, 3, 1);
      cycle_supply();
      p_u.seq(1, 3, 16);
      cycle_supply();
      rd(`FKD_REG_FUSE, d, 2'h0);
      chk((d >> 18) & 32'h1f, 32'h11);
      cycle_supply();
      chk({31'h0, cal}, 32'h1);
      chk({28'h0, freq}, 32'h1);
      n = 3;
      while (cal === 1'b1) begin
         @(posedge aclk);
         n++;
      end
      chk({31'h0, n >= 217 && n <= 223}, 32'h1);
      while (pwm !== 1'b1) @(posedge aclk);
      n = 0;
      while (pwm === 1'b1) begin
         @(posedge aclk);
         n++;
      end
      chk(n, 32'ha);
      p_u.seq(1, 6, 512);
      cycle_supply();
      chk({31'h0, lck}, 32'h1);
      p_u.seq(2, 1, 5);
      chk({23'h0, gain}, 32'h0);
      finish_test();
   end
endmodule
